// file: design/wseq_top.sv
/*
 * Control write sequencer with its target control registers, AHB-Lite slave.
 * Assumes a single AHB-Lite master, single word transfers, hclk at 40 MHz.
 */
// Notes on behaviour
// - run from the index in the start write until end flag
// - whole default program lasts about 280ms
// - entry 0 sets bias current select
// - entry 1 enables reference and buffer
// - entry 2 changes reference divider select
// - entries 3-6 enable bias, gains, clock
// - entry 7 enables both converters
// - entries 8,11,18,23,24 are dummy writes
// - entry 9 clears bit 4 of 04h
// - entry 10 enables charge pump, 4.5ms
// - entries 12-15 enable phone, line stages
// - entry 16 enables offset correction channels
// - entry 17 triggers start-up offset correction
// - entries 19-21 enable outputs, release shorts
// - entry 22 ends the sequence
// - step lasts 62.5us times 2^delay+8
// - only the start/width field is updated
// - writes to FFh change nothing
`timescale 1ns/1ps
module wseq_top #(
    parameter int STEP_UNIT_CYCLES = wseq_pkg::STEP_UNIT_CYCLES
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // block enables and sequencer busy
    output logic bias_enable,
    output logic reference_enable,
    output logic left_converter_enable,
    output logic right_converter_enable,
    output logic charge_pump_enable,
    output logic sequencer_busy
);
    localparam int AW = 5;

    // maps a register index onto a control register slot
    function automatic logic [3:0] reg_slot(input logic [7:0] a);
        case (a)
            wseq_pkg::REG_BIAS: reg_slot = 4'h0;
            wseq_pkg::REG_REFERENCE: reg_slot = 4'h1;
            wseq_pkg::REG_PHONE_GAIN: reg_slot = 4'h2;
            wseq_pkg::REG_LINE_GAIN: reg_slot = 4'h3;
            wseq_pkg::REG_CONVERTER: reg_slot = 4'h4;
            wseq_pkg::REG_CLOCKING: reg_slot = 4'h5;
            wseq_pkg::REG_OFFSET_ENABLE: reg_slot = 4'h6;
            wseq_pkg::REG_OFFSET_TRIGGER: reg_slot = 4'h7;
            wseq_pkg::REG_PHONE_STAGE: reg_slot = 4'h8;
            wseq_pkg::REG_LINE_STAGE: reg_slot = 4'h9;
            wseq_pkg::REG_CHARGE_PUMP: reg_slot = 4'hA;
            default: reg_slot = wseq_pkg::SLOT_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // bus address and data phase
    // ------------------------------------------------------------
    logic wr_phase;
    logic rd_phase;
    logic rd_wait;
    logic [7:0] phase_index;

    wire take = hsel && hready && htrans[1];
    wire [7:0] bus_index = phase_index;
    wire bus_wr = wr_phase;
    wire [3:0] bus_slot = reg_slot(bus_index);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_phase <= 1'b0;
            rd_phase <= 1'b0;
            phase_index <= 8'h00;
        end else if (hreadyout) begin
            wr_phase <= take && hwrite;
            rd_phase <= take && !hwrite;
            phase_index <= haddr[9:2];
        end
    end

    // one wait state on reads because the read data is registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_wait <= 1'b0;
        end else begin
            rd_wait <= rd_phase && !rd_wait;
        end
    end

    assign hreadyout = !(rd_phase && !rd_wait);
    assign hresp = 1'b0;

    // ------------------------------------------------------------
    // sequencer programming registers
    // ------------------------------------------------------------
    logic [AW-1:0] write_index;
    logic [14:0] seq_target;
    logic [14:0] seq_data;

    wire wr_index = bus_wr && bus_index == wseq_pkg::REG_SEQ_INDEX;
    wire wr_target = bus_wr && bus_index == wseq_pkg::REG_SEQ_TARGET;
    wire wr_data = bus_wr && bus_index == wseq_pkg::REG_SEQ_DATA;
    wire wr_start = bus_wr && bus_index == wseq_pkg::REG_SEQ_START;

    wire [14:0] next_target = wr_target ? hwdata[14:0] : seq_target;
    wire [14:0] next_data = wr_data ? hwdata[14:0] : seq_data;
    wire mem_wr = wr_target || wr_data;

    wire [wseq_pkg::ENTRY_W-1:0] mem_wdata = {next_data[wseq_pkg::SEQ_EOS_BIT],
        next_data[11:8], next_target[14:12], next_target[11:8], next_target[7:0],
        next_data[7:0]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            write_index <= '0;
            seq_target <= 15'h0000;
            seq_data <= 15'h0000;
        end else begin
            if (wr_index) begin
                write_index <= hwdata[AW-1:0];
            end
            seq_target <= next_target;
            seq_data <= next_data;
        end
    end

    // ------------------------------------------------------------
    // program memory
    // ------------------------------------------------------------
    logic [AW-1:0] cur_index;
    logic [wseq_pkg::ENTRY_W-1:0] entry;

    wseq_memory #(
        .WIDTH(wseq_pkg::ENTRY_W),
        .DEPTH(wseq_pkg::DEPTH),
        .AW(AW)
    ) u_memory (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(mem_wr),
        .wr_addr(write_index),
        .wr_data(mem_wdata),
        .rd_addr(cur_index),
        .rd_data(entry)
    );

    // ------------------------------------------------------------
    // entry decode and field merge
    // ------------------------------------------------------------
    wire [7:0] e_data = entry[wseq_pkg::E_DATA +: 8];
    wire [7:0] e_addr = entry[wseq_pkg::E_ADDR +: 8];
    wire [3:0] e_start = entry[wseq_pkg::E_START +: 4];
    wire [2:0] e_width = entry[wseq_pkg::E_WIDTH +: 3];
    wire [3:0] e_delay = entry[wseq_pkg::E_DELAY +: 4];
    wire e_eos = entry[wseq_pkg::E_EOS];

    wire [3:0] seq_slot = reg_slot(e_addr);
    // width code n covers n+1 bits
    wire [15:0] width_mask = 16'((17'h00002 << e_width) - 17'h00001);
    wire [15:0] field_mask = width_mask << e_start;
    wire [15:0] field_bits = ({8'h00, e_data} & width_mask) << e_start;
    wire [16:0] step_units = (17'h00001 << e_delay) + 17'(wseq_pkg::STEP_BASE_UNITS);

    // ------------------------------------------------------------
    // step state machine
    // ------------------------------------------------------------
    wseq_pkg::seq_state_t state;
    wseq_pkg::seq_state_t next_state;
    logic [15:0] unit_cnt;
    logic [16:0] units_left;
    logic [15:0] ctrl [wseq_pkg::CTRL_COUNT];

    wire unit_end = unit_cnt == 16'(STEP_UNIT_CYCLES - 1);
    wire step_end = state == wseq_pkg::ST_WAIT && unit_end && units_left == 17'h00001;
    wire go = wr_start && hwdata[wseq_pkg::START_GO_BIT];
    wire apply = state == wseq_pkg::ST_APPLY;

    always_comb begin
        next_state = state;
        case (state)
            wseq_pkg::ST_IDLE: next_state = go ? wseq_pkg::ST_FETCH : wseq_pkg::ST_IDLE;
            wseq_pkg::ST_FETCH: next_state = wseq_pkg::ST_APPLY;
            wseq_pkg::ST_APPLY: next_state = wseq_pkg::ST_WAIT;
            wseq_pkg::ST_WAIT: begin
                if (step_end) begin
                    next_state = e_eos ? wseq_pkg::ST_IDLE : wseq_pkg::ST_FETCH;
                end
            end
            default: next_state = wseq_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= wseq_pkg::ST_IDLE;
            cur_index <= '0;
        end else begin
            state <= next_state;
            // start ignored while busy
            if (state == wseq_pkg::ST_IDLE && go) begin
                cur_index <= hwdata[AW-1:0];
            end else if (step_end && !e_eos) begin
                cur_index <= cur_index + AW'(1);
            end
        end
    end

    // whole step including fetch and apply lasts step_units units
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unit_cnt <= 16'h0000;
            units_left <= 17'h00000;
        end else if (state == wseq_pkg::ST_IDLE) begin
            unit_cnt <= 16'h0000;
            units_left <= 17'h00000;
        end else if (step_end) begin
            unit_cnt <= 16'h0000;
        end else begin
            unit_cnt <= unit_end ? 16'h0000 : unit_cnt + 16'h0001;
            if (apply) begin
                units_left <= step_units;
            end else if (unit_end) begin
                units_left <= units_left - 17'h00001;
            end
        end
    end

    // ------------------------------------------------------------
    // control registers: bus write after sequencer merge
    // ------------------------------------------------------------
    for (genvar i = 0; i < wseq_pkg::CTRL_COUNT; i++) begin : g_ctrl
        wire seq_hit = apply && seq_slot == 4'(i);
        wire bus_hit = bus_wr && bus_slot == 4'(i);

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ctrl[i] <= wseq_pkg::CTRL_RESET;
            end else if (bus_hit) begin
                ctrl[i] <= hwdata[15:0];
            end else if (seq_hit) begin
                ctrl[i] <= (ctrl[i] & ~field_mask) | field_bits;
            end
        end
    end

    // ------------------------------------------------------------
    // read data and block outputs
    // ------------------------------------------------------------
    wire busy = state != wseq_pkg::ST_IDLE;
    wire [15:0] ctrl_rd = (bus_slot == wseq_pkg::SLOT_NONE) ? 16'h0000 : ctrl[bus_slot];
    wire [15:0] start_rd = {7'h00, busy, 3'h0, cur_index};

    wire [15:0] read_value =
        (bus_index == wseq_pkg::REG_SEQ_INDEX) ? {11'h000, write_index} :
        (bus_index == wseq_pkg::REG_SEQ_TARGET) ? {1'b0, seq_target} :
        (bus_index == wseq_pkg::REG_SEQ_DATA) ? {1'b0, seq_data} :
        (bus_index == wseq_pkg::REG_SEQ_START) ? start_rd : ctrl_rd;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_phase && !rd_wait) begin
            hrdata <= {16'h0000, read_value};
        end
    end

    assign bias_enable = ctrl[0][0];
    assign reference_enable = ctrl[1][0];
    assign right_converter_enable = ctrl[4][2];
    assign left_converter_enable = ctrl[4][3];
    assign charge_pump_enable = ctrl[10][0];
    assign sequencer_busy = busy;
endmodule

// file: design/wseq_pkg.sv
/*
 * Package of the start-up write sequencer: register indexes, entry layout,
 * step timing and the default program.
 * Assumes a 40 MHz hclk and 32-bit single-word AHB-Lite access.
 */
package wseq_pkg;

    // ------------------------------------------------------------
    // register indexes (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_BIAS = 8'h04;
    localparam logic [7:0] REG_REFERENCE = 8'h05;
    localparam logic [7:0] REG_PHONE_GAIN = 8'h0E;
    localparam logic [7:0] REG_LINE_GAIN = 8'h0F;
    localparam logic [7:0] REG_CONVERTER = 8'h12;
    localparam logic [7:0] REG_CLOCKING = 8'h16;
    localparam logic [7:0] REG_OFFSET_ENABLE = 8'h43;
    localparam logic [7:0] REG_OFFSET_TRIGGER = 8'h44;
    localparam logic [7:0] REG_PHONE_STAGE = 8'h5A;
    localparam logic [7:0] REG_LINE_STAGE = 8'h5E;
    localparam logic [7:0] REG_CHARGE_PUMP = 8'h62;
    localparam logic [7:0] REG_SEQ_INDEX = 8'h6C;
    localparam logic [7:0] REG_SEQ_TARGET = 8'h6D;
    localparam logic [7:0] REG_SEQ_DATA = 8'h6E;
    localparam logic [7:0] REG_SEQ_START = 8'h6F;
    localparam logic [7:0] REG_DUMMY = 8'hFF;
    localparam int CTRL_COUNT = 11;
    localparam logic [3:0] SLOT_NONE = 4'hF;

    // ------------------------------------------------------------
    // sequencer register fields and reset values
    // ------------------------------------------------------------
    localparam int START_GO_BIT = 8;
    localparam int BUSY_BIT = 8;
    localparam int SEQ_EOS_BIT = 14;
    localparam int SEQ_FIELD_BIT = 8;
    localparam int SEQ_WIDTH_BIT = 12;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // ------------------------------------------------------------
    // memory entry layout: eos, delay, width, start, addr, data
    // ------------------------------------------------------------
    localparam int ENTRY_W = 28;
    localparam int DEPTH = 32;
    localparam int E_DATA = 0;
    localparam int E_ADDR = 8;
    localparam int E_START = 16;
    localparam int E_WIDTH = 20;
    localparam int E_DELAY = 23;
    localparam int E_EOS = 27;

    // ------------------------------------------------------------
    // step timing: unit of 62.5 us, step = unit * (2^delay + 8)
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int STEP_UNIT_PS = 62500000;
    localparam int STEP_UNIT_CYCLES = STEP_UNIT_PS / CLK_PERIOD_PS;
    localparam int STEP_BASE_UNITS = 8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_APPLY = 2'b11,
        ST_WAIT = 2'b10
    } seq_state_t;

    function automatic logic [ENTRY_W-1:0] mk(input logic [7:0] addr,
                                              input logic [2:0] width,
                                              input logic [3:0] start,
                                              input logic [7:0] data,
                                              input logic [3:0] delay,
                                              input logic eos);
        mk = {eos, delay, width, start, addr, data};
    endfunction

    // default program; unused entries are dummy writes
    function automatic logic [ENTRY_W-1:0] default_entry(input int idx);
        case (idx)
            0: default_entry = mk(REG_BIAS, 3'h4, 4'h0, 8'h1A, 4'h0, 1'b0);
            1: default_entry = mk(REG_REFERENCE, 3'h7, 4'h0, 8'h47, 4'h6, 1'b0);
            2: default_entry = mk(REG_REFERENCE, 3'h1, 4'h1, 8'h01, 4'h0, 1'b0);
            3: default_entry = mk(REG_BIAS, 3'h0, 4'h0, 8'h01, 4'h0, 1'b0);
            4: default_entry = mk(REG_PHONE_GAIN, 3'h1, 4'h0, 8'h03, 4'h0, 1'b0);
            5: default_entry = mk(REG_LINE_GAIN, 3'h1, 4'h0, 8'h03, 4'h0, 1'b0);
            6: default_entry = mk(REG_CLOCKING, 3'h0, 4'h1, 8'h01, 4'h0, 1'b0);
            7: default_entry = mk(REG_CONVERTER, 3'h1, 4'h2, 8'h03, 4'h5, 1'b0);
            9: default_entry = mk(REG_BIAS, 3'h0, 4'h4, 8'h00, 4'h0, 1'b0);
            10: default_entry = mk(REG_CHARGE_PUMP, 3'h0, 4'h0, 8'h01, 4'h6, 1'b0);
            12: default_entry = mk(REG_PHONE_STAGE, 3'h7, 4'h0, 8'h11, 4'h0, 1'b0);
            13: default_entry = mk(REG_LINE_STAGE, 3'h7, 4'h0, 8'h11, 4'h0, 1'b0);
            14: default_entry = mk(REG_PHONE_STAGE, 3'h7, 4'h0, 8'h33, 4'h0, 1'b0);
            15: default_entry = mk(REG_LINE_STAGE, 3'h7, 4'h0, 8'h33, 4'h0, 1'b0);
            16: default_entry = mk(REG_OFFSET_ENABLE, 3'h3, 4'h0, 8'h0F, 4'hC, 1'b0);
            17: default_entry = mk(REG_OFFSET_TRIGGER, 3'h7, 4'h0, 8'hF0, 4'h0, 1'b0);
            19: default_entry = mk(REG_PHONE_STAGE, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0);
            20: default_entry = mk(REG_LINE_STAGE, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0);
            21: default_entry = mk(REG_PHONE_STAGE, 3'h7, 4'h0, 8'hFF, 4'h0, 1'b0);
            22: default_entry = mk(REG_LINE_STAGE, 3'h7, 4'h0, 8'hFF, 4'h0, 1'b1);
            default: default_entry = mk(REG_DUMMY, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0);
        endcase
    endfunction

endpackage

// file: design/wseq_memory.sv
/*
 * Sequencer program memory: one write port, registered read data.
 * Assumes hardware reset only; each word comes up holding the default program.
 */
`timescale 1ns/1ps
module wseq_memory #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // read port
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] words [DEPTH];

    // ------------------------------------------------------------
    // storage, reset to the default program
    // ------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++) begin : g_word
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                words[i] <= WIDTH'(wseq_pkg::default_entry(i));
            end else if (wr_en && wr_addr == AW'(i)) begin
                words[i] <= wr_data;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_data <= '0;
        end else begin
            rd_data <= words[rd_addr];
        end
    end
endmodule

// file: dv/wseq_asserts.sv
/*
 * Checker of the sequencer top ports: bus timing, busy span, enable order.
 * Assumes hready is tied to hreadyout and a single bus master.
 */
`timescale 1ns/1ps
module wseq_checker #(
    parameter int STEP_UNIT_CYCLES = wseq_pkg::STEP_UNIT_CYCLES
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // block enables and sequencer busy
    input wire logic bias_enable,
    input wire logic reference_enable,
    input wire logic left_converter_enable,
    input wire logic right_converter_enable,
    input wire logic charge_pump_enable,
    input wire logic sequencer_busy
);
    localparam int MIN_STEP = 9 * STEP_UNIT_CYCLES;
    logic wr_q;
    logic rd_q;
    logic start_q;
    logic [15:0] busy_cnt;
    wire logic take = hsel && hready && htrans[1];
    wire logic [4:0] enables = {bias_enable, reference_enable, left_converter_enable,
                                right_converter_enable, charge_pump_enable};

    // ------------------------------------------------------------
    // data phase tracking and busy length
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            start_q <= 1'b0;
            busy_cnt <= 16'h0000;
        end else begin
            if (hready) begin
                wr_q <= take && hwrite;
                rd_q <= take && !hwrite;
                start_q <= take && hwrite && (haddr[9:2] == 8'h6F);
            end
            busy_cnt <= sequencer_busy ? busy_cnt + 16'h0001 : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    AST_WRITE_NO_WAIT: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    AST_READ_ONE_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    AST_RESP_OKAY: assert property (hresp == 1'b0)
        else $error("response not okay");
    AST_RDATA_UPPER: assert property (rd_q && hreadyout |-> hrdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    AST_START_BUSY: assert property (
        start_q && hready && hwdata[8] && !sequencer_busy |=> sequencer_busy)
        else $error("start write did not raise busy");
    AST_STEP_MIN: assert property ($fell(sequencer_busy) |-> busy_cnt >= MIN_STEP)
        else $error("sequence shorter than one step");
    AST_IDLE_STABLE: assert property (!sequencer_busy && !wr_q |=> $stable(enables))
        else $error("enable changed while idle");
    AST_BIAS_AFTER_REF: assert property (
        sequencer_busy && $rose(bias_enable) |-> reference_enable)
        else $error("bias enabled before reference");
    AST_CONV_PAIR: assert property (
        sequencer_busy && $rose(left_converter_enable) |-> $rose(right_converter_enable))
        else $error("converters not enabled together");
    AST_PUMP_AFTER_CONV: assert property (
        sequencer_busy && $rose(charge_pump_enable) |-> left_converter_enable)
        else $error("charge pump before converters");
endmodule

bind wseq_top wseq_checker #(.STEP_UNIT_CYCLES(STEP_UNIT_CYCLES)) wseq_checker_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bias_enable(bias_enable),
    .reference_enable(reference_enable), .left_converter_enable(left_converter_enable),
    .right_converter_enable(right_converter_enable),
    .charge_pump_enable(charge_pump_enable), .sequencer_busy(sequencer_busy)
);

// file: dv/ahb_host.sv
/*
 * Host processor model: ahb-lite master with single word transfers.
 * Assumes one slave whose hreadyout is the bus hready.
 */
`timescale 1ns/1ps
module ahb_host (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus answer
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // bus request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h00000000;
    end

    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] d,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h000000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {16'h0000, d};
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        // released data bus must not keep the last value
        hwdata <= ~hwdata;
    endtask

    task automatic write_reg(input logic [7:0] idx, input logic [15:0] d);
        logic [31:0] unused;
        xfer(1'b1, idx, d, unused);
    endtask

    task automatic read_reg(input logic [7:0] idx, output logic [31:0] rd);
        xfer(1'b0, idx, 16'h0000, rd);
    endtask

    task automatic start_default();
        write_reg(8'h6F, 16'h0100);
    endtask

    // entry 18 made a dummy write for quick start-up
    task automatic fast_startup();
        write_reg(8'h6C, 16'h0012);
        write_reg(8'h6D, 16'h00FF);
        write_reg(8'h6E, 16'h0000);
    endtask
endmodule

// file: dv/tb_top.sv
/*
 * Testbench of the start-up write sequencer: reset values, a custom program, the default run.
 * Assumes the host model drives the bus and the step unit is shortened to 4 cycles.
 */
`timescale 1ns/1ps
module tb_top;
    localparam int UNIT = 4;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    wire [4:0] en;
    logic sequencer_busy;
    logic [31:0] rd;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int t0;
    int units;
    logic [7:0] idx_list [11] = '{8'h04, 8'h05, 8'h0E, 8'h0F, 8'h12, 8'h16, 8'h43, 8'h44,
                                  8'h5A, 8'h5E, 8'h62};
    logic [15:0] final_val [11] = '{16'h000B, 16'h0043, 16'h0003, 16'h0003, 16'h000C, 16'h0002,
                                    16'h000F, 16'h00F0, 16'h00FF, 16'h00FF, 16'h0001};
    int dly [23] = '{0, 6, 0, 0, 0, 0, 0, 5, 0, 0, 6, 0, 0, 0, 0, 0, 12, 0, 0, 0, 0, 0, 0};

    wseq_top #(.STEP_UNIT_CYCLES(UNIT)) wseq_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bias_enable(en[4]),
        .reference_enable(en[3]), .left_converter_enable(en[2]),
        .right_converter_enable(en[1]), .charge_pump_enable(en[0]),
        .sequencer_busy(sequencer_busy));
    ahb_host host_inst (
        .hclk(hclk), .hresetn(hresetn), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    always @(posedge hclk) cyc <= cyc + 1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        host_inst.read_reg(idx, v);
        check(v, exp);
    endtask

    task automatic do_reset();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
    endtask

    // returns at the first edge with busy low
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (sequencer_busy === 1'b1 && n < 30000);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge hclk);
        error_cnt++;
        give_verdict();
    end

    initial begin
        hresetn = 1'b0;
        do_reset();
        // ------------------------------------------------------------
        // reset values and unmapped index
        // ------------------------------------------------------------
        check({26'h0, sequencer_busy, en}, 32'h00000000);
        foreach (idx_list[i]) rd_check(idx_list[i], 32'h00000000);
        host_inst.write_reg(8'h30, 16'hBEEF);
        rd_check(8'h30, 32'h00000000);
        $display("test reset values done");
        // ------------------------------------------------------------
        // custom program at 30: field write then dummy with delay 1
        // ------------------------------------------------------------
        host_inst.write_reg(8'h04, 16'hFFFF);
        host_inst.write_reg(8'h05, 16'h1234);
        host_inst.write_reg(8'h6C, 16'h001E);
        host_inst.write_reg(8'h6D, 16'h2404);
        host_inst.write_reg(8'h6E, 16'h00FA);
        host_inst.write_reg(8'h6C, 16'h001F);
        host_inst.write_reg(8'h6D, 16'h00FF);
        host_inst.write_reg(8'h6E, 16'h415A);
        host_inst.write_reg(8'h6F, 16'h011E);
        t0 = cyc;
        wait_idle();
        check(32'(cyc - t0 - 1), 32'(19 * UNIT));
        rd_check(8'h04, 32'h0000FFAF);
        rd_check(8'h05, 32'h00001234);
        $display("test custom program done");
        // ------------------------------------------------------------
        // default start-up after a second reset
        // ------------------------------------------------------------
        do_reset();
        rd_check(8'h04, 32'h00000000);
        host_inst.fast_startup();
        units = 0;
        foreach (dly[i]) units += (1 << dly[i]) + 8;
        host_inst.start_default();
        t0 = cyc;
        host_inst.write_reg(8'h6F, 16'h011E);
        host_inst.read_reg(8'h6F, rd);
        check(rd, 32'h00000100);
        wait_idle();
        check(32'(cyc - t0 - 1), 32'(units * UNIT));
        foreach (idx_list[i]) rd_check(idx_list[i], {16'h0000, final_val[i]});
        check({27'h0, en}, 32'h0000001F);
        host_inst.read_reg(8'h6F, rd);
        check(rd, 32'h00000016);
        $display("test default start-up done");
        give_verdict();
    end
endmodule
